// File: rtl/fcs_consts.svh
// offsets, field positions, reset values and opcodes of the floppy command tail block
// Operation
// RULE1: decode offsets 0-5 and 7, split read/write
// RULE2: offset 0 reads snapshot of drive pins
// RULE3: status A layout follows compatibility mode
// RULE4: status A bit 7 is interrupt level
// RULE5: first mode bit 6: second drive absent
// RULE6: alternate mode bit 6: DMA request level
// RULE7: bit 0 direction, polarity per mode
// RULE8: first mode bit 2 true index level
// RULE9: alternate mode bit 2 inverted index
// RULE10: first mode bit 1 low when protected
// RULE11: alternate mode bit 1 high when protected
// RULE12: register dump returns ten internal values
// RULE13: invalid opcode returns single byte 80H
// RULE14: sense drive status: select byte, one result
// RULE15: queue disabled after reset, configure changes it
// RULE16: configure: zero byte, settings byte, precomp track
// RULE17: lock flag opcode bit 7, result bit 4
// RULE18: relative seek: direction bit 6, select, count
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH
`define FCS_OFS_PIN_A 3'h0
`define FCS_OFS_PIN_B 3'h1
`define FCS_OFS_DOUT 3'h2
`define FCS_OFS_TAPE 3'h3
`define FCS_OFS_MAIN 3'h4
`define FCS_OFS_DATA 3'h5
`define FCS_OFS_DIN 3'h7
`define FCS_OP_CONFIG 8'h13
`define FCS_OP_RSEEK 8'h8F
`define FCS_RSEEK_MASK 8'hBF
`define FCS_OP_DUMP 8'h0E
`define FCS_OP_PERP 8'h12
`define FCS_OP_LOCK 8'h14
`define FCS_LOCK_MASK 8'h7F
`define FCS_OP_SENSE 8'h04
`define FCS_OP_SPEC 8'h03
`define FCS_INVALID_ST0 8'h80
`define FCS_DUMP_LEN 4'hA
`define FCS_LOCK_BIT 7
`define FCS_DIR_BIT 6
`define FCS_SRESET_BIT 7
`define FCS_QDIS_RST 1'b1
`define FCS_THR_RST 4'h0
`define FCS_EOT_RST 8'h00
`endif

// File: rtl/fcs_pkg.sv
// types shared by the floppy command tail block
`default_nettype none
package fcs_pkg;
   typedef enum logic [1:0] {ST_CMD, ST_PARAM, ST_LOAD, ST_RESULT} fcs_state_e;
   typedef enum logic [2:0] {K_INV, K_CFG, K_RSEEK, K_DUMP, K_PERP, K_LOCK, K_SENSE, K_SPEC} fcs_kind_e;
   typedef struct packed {
      logic index;
      logic write_prot;
      logic track0_n;
      logic disk_change;
      logic second_drive_absent;
      logic compat_alt;
   } fcs_pins_s;
   typedef struct packed {
      logic implied_seek_enable;
      logic qdis;
      logic poll;
      logic [3:0] thr;
      logic [7:0] precomp_start_track;
   } fcs_cfg_s;
endpackage
`default_nettype wire

// File: rtl/fcs_res_mem.sv
// result byte store with registered read data
`default_nettype none
module fcs_res_mem
(
   input wire logic clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [3:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [3:0] raddr,
   output logic [7:0] rdata_q
);
   logic [7:0] mem [16];
   always_ff @(posedge clk)
   begin
      if (we)
         mem[waddr] <= wdata;
   end
   always_ff @(posedge clk)
   begin
      if (rst)
         rdata_q <= 8'h00;
      else
         rdata_q <= mem[raddr];
   end
endmodule
`default_nettype wire

// File: rtl/fcs_sync.sv
// two flip-flop synchroniser for drive pin levels
`default_nettype none
module fcs_sync #(parameter int W = 6)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge clk)
         begin
            meta_q[i] <= rst ? 1'b0 : async_in[i];
            sync_out[i] <= rst ? 1'b0 : meta_q[i];
         end
      end
   endgenerate
endmodule
`default_nettype wire

// File: rtl/fcs_top.sv
// floppy command tail interpreter with host register map on avalon-mm
//
// Implementation choice: register access over Avalon-MM.
`include "fcs_consts.svh"
`default_nettype none
module fcs_top
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [7:0] avs_writedata,
   output logic [7:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic index_pin,
   input wire logic write_prot_pin,
   input wire logic track0_n_pin,
   input wire logic disk_change_pin,
   input wire logic second_drive_absent,
   input wire logic compat_alt_pin,
   output logic irq,
   output logic dma_request_out,
   output logic step_inward,
   output logic head_select,
   output logic [1:0] drive_select,
   output logic [3:0] motor_enable
);
   // ----------------------------------------
   // decoding helpers
   // ----------------------------------------
   function automatic fcs_pkg::fcs_kind_e op_kind(input logic [7:0] op);
      if (op == `FCS_OP_CONFIG)
         return fcs_pkg::K_CFG;
      else if ((op & `FCS_RSEEK_MASK) == `FCS_OP_RSEEK)
         return fcs_pkg::K_RSEEK;
      else if (op == `FCS_OP_DUMP)
         return fcs_pkg::K_DUMP;
      else if (op == `FCS_OP_PERP)
         return fcs_pkg::K_PERP;
      else if ((op & `FCS_LOCK_MASK) == `FCS_OP_LOCK)
         return fcs_pkg::K_LOCK;
      else if (op == `FCS_OP_SENSE)
         return fcs_pkg::K_SENSE;
      else if (op == `FCS_OP_SPEC)
         return fcs_pkg::K_SPEC;
      else
         return fcs_pkg::K_INV;
   endfunction

   function automatic logic [1:0] param_cnt(input fcs_pkg::fcs_kind_e k);
      unique case (k)
         fcs_pkg::K_CFG: return 2'd3;
         fcs_pkg::K_RSEEK, fcs_pkg::K_SPEC: return 2'd2;
         fcs_pkg::K_PERP, fcs_pkg::K_SENSE: return 2'd1;
         fcs_pkg::K_INV, fcs_pkg::K_DUMP, fcs_pkg::K_LOCK: return 2'd0;
      endcase
   endfunction

   function automatic logic [3:0] result_len(input fcs_pkg::fcs_kind_e k);
      unique case (k)
         fcs_pkg::K_DUMP: return `FCS_DUMP_LEN;
         fcs_pkg::K_INV, fcs_pkg::K_LOCK, fcs_pkg::K_SENSE: return 4'h1;
         fcs_pkg::K_CFG, fcs_pkg::K_RSEEK, fcs_pkg::K_PERP, fcs_pkg::K_SPEC: return 4'h0;
      endcase
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   fcs_pkg::fcs_pins_s pins_raw;
   fcs_pkg::fcs_pins_s pins;
   fcs_pkg::fcs_state_e st_q;
   fcs_pkg::fcs_kind_e kind_q;
   fcs_pkg::fcs_cfg_s cfg_q;
   logic [7:0] op_q;
   logic [7:0] p0_q;
   logic [7:0] p1_q;
   logic [1:0] pcnt_q;
   logic [3:0] len_q;
   logic [3:0] ld_idx_q;
   logic [3:0] rd_ptr_q;
   logic gap_q;
   logic wait_q;
   logic [7:0] rdata_q;
   logic irq_q;
   logic dma_q;
   logic dir_q;
   logic head_q;
   logic [2:0] sel_q;
   logic lock_q;
   logic [3:0] perp_q;
   logic gap_bit_q;
   logic wg_q;
   logic [3:0] srt_q;
   logic [3:0] hut_q;
   logic [6:0] hlt_q;
   logic nd_q;
   logic [7:0] eot_q;
   logic [7:0] pcn_q [4];
   logic [7:0] dout_q;
   logic [1:0] tape_q;
   logic [1:0] drate_q;
   logic noprec_q;
   logic [7:0] mem_rdata;

   assign pins_raw = '{index: index_pin, write_prot: write_prot_pin, track0_n: track0_n_pin,
                       disk_change: disk_change_pin, second_drive_absent: second_drive_absent,
                       compat_alt: compat_alt_pin};

   fcs_sync #(.W($bits(fcs_pkg::fcs_pins_s))) u_sync
   (
      .clk(clk),
      .rst(rst),
      .async_in(pins_raw),
      .sync_out(pins)
   );

   // ----------------------------------------
   // avalon slave handshake
   // ----------------------------------------
   wire req = avs_read | avs_write;
   wire hold = (st_q == fcs_pkg::ST_LOAD) | gap_q;
   wire accept = req & wait_q & ~hold;
   wire fire = req & ~wait_q;
   wire wr_fire = fire & avs_write;
   wire rd_fire = fire & avs_read;
   wire wr_data = wr_fire & (avs_address == `FCS_OFS_DATA); // [RULE1]
   wire wr_rate = wr_fire & (avs_address == `FCS_OFS_MAIN); // [RULE1]
   wire wr_cc = wr_fire & (avs_address == `FCS_OFS_DIN); // [RULE1]
   wire wr_dout = wr_fire & (avs_address == `FCS_OFS_DOUT);
   wire wr_tape = wr_fire & (avs_address == `FCS_OFS_TAPE);
   wire pop = rd_fire & (avs_address == `FCS_OFS_DATA) & (st_q == fcs_pkg::ST_RESULT);
   wire sreset = wr_rate & avs_writedata[`FCS_SRESET_BIT];

   // ----------------------------------------
   // command sequencing
   // ----------------------------------------
   wire [7:0] wd = avs_writedata;
   fcs_pkg::fcs_kind_e dec_kind;
   fcs_pkg::fcs_kind_e ex_kind;
   assign dec_kind = op_kind(wd);
   assign ex_kind = (st_q == fcs_pkg::ST_CMD) ? dec_kind : kind_q;
   wire [7:0] ex_op = (st_q == fcs_pkg::ST_CMD) ? wd : op_q;
   wire cmd_wr = wr_data & (st_q == fcs_pkg::ST_CMD);
   wire last_par = wr_data & (st_q == fcs_pkg::ST_PARAM) & (pcnt_q == param_cnt(kind_q) - 2'd1);
   wire exec = (cmd_wr & (param_cnt(dec_kind) == 2'd0)) | last_par;
   wire [3:0] ex_len = result_len(ex_kind);
   wire [1:0] rs_drv = p0_q[1:0];
   wire [7:0] rs_next = op_q[`FCS_DIR_BIT] ? pcn_q[rs_drv] + wd : pcn_q[rs_drv] - wd;

   always_ff @(posedge clk)
   begin
      if (rst | sreset)
      begin
         st_q <= fcs_pkg::ST_CMD;
         kind_q <= fcs_pkg::K_INV;
         op_q <= 8'h00;
         pcnt_q <= 2'd0;
         len_q <= 4'h0;
      end
      else if (exec)
      begin
         kind_q <= ex_kind;
         len_q <= ex_len;
         st_q <= (ex_len == 4'h0) ? fcs_pkg::ST_CMD : fcs_pkg::ST_LOAD;
      end
      else if (cmd_wr)
      begin
         kind_q <= dec_kind;
         op_q <= wd;
         pcnt_q <= 2'd0;
         st_q <= fcs_pkg::ST_PARAM;
      end
      else if (wr_data & (st_q == fcs_pkg::ST_PARAM))
         pcnt_q <= pcnt_q + 2'd1;
      else if ((st_q == fcs_pkg::ST_LOAD) & (ld_idx_q == len_q - 4'h1))
         st_q <= fcs_pkg::ST_RESULT;
      else if (pop & (rd_ptr_q == len_q - 4'h1))
         st_q <= fcs_pkg::ST_CMD;
   end

   // parameter capture, first two bytes
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         p0_q <= 8'h00;
         p1_q <= 8'h00;
      end
      else if (wr_data & (st_q == fcs_pkg::ST_PARAM) & (pcnt_q == 2'd0))
         p0_q <= wd;
      else if (wr_data & (st_q == fcs_pkg::ST_PARAM) & (pcnt_q == 2'd1))
         p1_q <= wd;
   end

   // ----------------------------------------
   // command effects
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst | (sreset & ~lock_q))
         cfg_q <= '{implied_seek_enable: 1'b0, qdis: `FCS_QDIS_RST, poll: 1'b0, thr: `FCS_THR_RST, precomp_start_track: 8'h00}; // [RULE15]
      else if (exec & (ex_kind == fcs_pkg::K_CFG))
         cfg_q <= '{implied_seek_enable: p1_q[6], qdis: p1_q[5], poll: p1_q[4], thr: p1_q[3:0], precomp_start_track: wd}; // [RULE16]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         lock_q <= 1'b0;
      else if (exec & (ex_kind == fcs_pkg::K_LOCK))
         lock_q <= ex_op[`FCS_LOCK_BIT]; // [RULE17]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         perp_q <= 4'h0;
         gap_bit_q <= 1'b0;
         wg_q <= 1'b0;
      end
      else if (exec & (ex_kind == fcs_pkg::K_PERP))
      begin
         if (wd[7])
            perp_q <= wd[5:2];
         gap_bit_q <= wd[1];
         wg_q <= wd[0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         srt_q <= 4'h0;
         hut_q <= 4'h0;
         hlt_q <= 7'h00;
         nd_q <= 1'b0;
         eot_q <= `FCS_EOT_RST;
      end
      else if (exec & (ex_kind == fcs_pkg::K_SPEC))
      begin
         srt_q <= p0_q[7:4];
         hut_q <= p0_q[3:0];
         hlt_q <= wd[7:1];
         nd_q <= wd[0];
      end
   end

   // relative seek moves the present cylinder at once and raises the interrupt
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_pcn
         always_ff @(posedge clk)
         begin
            if (rst)
               pcn_q[g] <= 8'h00;
            else if (exec & (ex_kind == fcs_pkg::K_RSEEK) & (rs_drv == 2'(g)))
               pcn_q[g] <= rs_next; // [RULE18]
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dir_q <= 1'b0;
         head_q <= 1'b0;
         sel_q <= 3'h0;
         irq_q <= 1'b0;
      end
      else if (exec & (ex_kind == fcs_pkg::K_RSEEK))
      begin
         dir_q <= op_q[`FCS_DIR_BIT]; // [RULE18]
         head_q <= p0_q[2];
         sel_q <= p0_q[2:0];
         irq_q <= 1'b1;
      end
      else if (exec & (ex_kind == fcs_pkg::K_SENSE))
         sel_q <= wd[2:0]; // [RULE14]
      else if (cmd_wr | sreset)
         irq_q <= 1'b0;
   end

   // ----------------------------------------
   // result loading
   // ----------------------------------------
   wire [7:0] st3 = {1'b0, pins.write_prot, 1'b1, ~pins.track0_n, 1'b1, sel_q}; // [RULE14]
   wire [7:0] dump_v [10];
   assign dump_v[0] = pcn_q[0]; // [RULE12]
   assign dump_v[1] = pcn_q[1];
   assign dump_v[2] = pcn_q[2];
   assign dump_v[3] = pcn_q[3];
   assign dump_v[4] = {srt_q, hut_q};
   assign dump_v[5] = {hlt_q, nd_q};
   assign dump_v[6] = eot_q;
   assign dump_v[7] = {lock_q, 1'b0, perp_q, gap_bit_q, wg_q};
   assign dump_v[8] = {1'b0, cfg_q.implied_seek_enable, cfg_q.qdis, cfg_q.poll, cfg_q.thr};
   assign dump_v[9] = cfg_q.precomp_start_track;
   wire [7:0] lock_res = {3'b000, lock_q, 4'h0}; // [RULE17]
   wire [7:0] res_byte = (kind_q == fcs_pkg::K_DUMP) ? dump_v[ld_idx_q] :
                         (kind_q == fcs_pkg::K_LOCK) ? lock_res :
                         (kind_q == fcs_pkg::K_SENSE) ? st3 :
                         `FCS_INVALID_ST0; // [RULE13]
   wire loading = (st_q == fcs_pkg::ST_LOAD);

   always_ff @(posedge clk)
   begin
      if (rst | exec)
      begin
         ld_idx_q <= 4'h0;
         rd_ptr_q <= 4'h0;
      end
      else
      begin
         if (loading)
            ld_idx_q <= ld_idx_q + 4'h1;
         if (pop)
            rd_ptr_q <= rd_ptr_q + 4'h1;
      end
   end

   fcs_res_mem u_mem
   (
      .clk(clk),
      .rst(rst),
      .we(loading),
      .waddr(ld_idx_q),
      .wdata(res_byte),
      .raddr(rd_ptr_q),
      .rdata_q(mem_rdata)
   );

   // ----------------------------------------
   // host side registers
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dout_q <= 8'h00;
         tape_q <= 2'b00;
         drate_q <= 2'b00;
         noprec_q <= 1'b0;
         dma_q <= 1'b0;
      end
      else
      begin
         if (wr_dout)
            dout_q <= wd;
         if (wr_tape)
            tape_q <= wd[1:0];
         if (wr_rate | wr_cc)
            drate_q <= wd[1:0];
         if (wr_cc)
            noprec_q <= wd[2];
      end
   end

   // ----------------------------------------
   // read selection
   // ----------------------------------------
   wire alt = pins.compat_alt;
   wire [7:0] pin_a_first = {irq_q, pins.second_drive_absent, 1'b0, pins.track0_n, head_q, pins.index,
                             ~pins.write_prot, dir_q}; // [RULE4] [RULE5] [RULE8] [RULE10] [RULE7]
   wire [7:0] pin_a_alt = {irq_q, dma_q, 1'b0, ~pins.track0_n, ~head_q, ~pins.index,
                           pins.write_prot, ~dir_q}; // [RULE4] [RULE6] [RULE9] [RULE11] [RULE7]
   wire [7:0] pin_a = alt ? pin_a_alt : pin_a_first; // [RULE2] [RULE3]
   wire [7:0] pin_b = {2'b11, dout_q[0], 3'b000, dout_q[5], dout_q[4]};
   wire high_dens = (drate_q == 2'b01) | (drate_q == 2'b10);
   wire [7:0] din_first = {pins.disk_change, 4'hF, drate_q, high_dens};
   wire [7:0] din_alt = {~pins.disk_change, 3'b111, dout_q[3], noprec_q, drate_q};
   wire busy = (st_q != fcs_pkg::ST_CMD);
   wire [7:0] main_st = {~loading, st_q == fcs_pkg::ST_RESULT, 1'b0, busy, 4'h0};
   wire [7:0] rd_mux = (avs_address == `FCS_OFS_PIN_A) ? pin_a :
                       (avs_address == `FCS_OFS_PIN_B) ? pin_b :
                       (avs_address == `FCS_OFS_TAPE) ? {6'h00, tape_q} :
                       (avs_address == `FCS_OFS_MAIN) ? main_st :
                       (avs_address == `FCS_OFS_DATA) ? mem_rdata :
                       (avs_address == `FCS_OFS_DIN) ? (alt ? din_alt : din_first) :
                       8'h00; // [RULE1]

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wait_q <= 1'b1;
         rdata_q <= 8'h00;
         gap_q <= 1'b0;
      end
      else
      begin
         wait_q <= ~accept;
         gap_q <= pop | loading;
         if (accept & avs_read)
            rdata_q <= rd_mux;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign irq = irq_q;
   assign dma_request_out = dma_q;
   assign step_inward = dir_q;
   assign head_select = head_q;
   assign drive_select = dout_q[1:0];
   assign motor_enable = dout_q[7:4];
endmodule
`default_nettype wire

// File: testbench/fcs_drive_model.sv
// drive side model presenting pin levels chosen by the bench
`default_nettype none
module fcs_drive_model
(
   input wire logic [3:0] motor_enable,
   input wire logic [1:0] drive_select,
   input wire fcs_pkg::fcs_pins_s ctl,
   output var fcs_pkg::fcs_pins_s pins
);
   timeunit 1ns;
   timeprecision 1ns;
   always_comb
   begin
      pins = ctl;
      // index pulses only while the selected drive spins
      pins.index = ctl.index & motor_enable[drive_select];
   end
endmodule
`default_nettype wire

// File: testbench/fcs_top_asserts.sv
// assertion checker for the floppy command tail block
`default_nettype none
module fcs_top_asserts
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [7:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic index_pin,
   input wire logic write_prot_pin,
   input wire logic track0_n_pin,
   input wire logic second_drive_absent,
   input wire logic compat_alt_pin,
   input wire logic irq,
   input wire logic dma_request_out,
   input wire logic step_inward
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] pins;
   logic [4:0] h1_q, h2_q, h3_q, h4_q, h5_q;
   wire quiet = (h1_q == pins) && (h2_q == pins) && (h3_q == pins) && (h4_q == pins) && (h5_q == pins);
   wire rd0 = avs_read && (avs_address == 3'h0) && !avs_waitrequest && quiet;
   assign pins = {index_pin, write_prot_pin, track0_n_pin, second_drive_absent, compat_alt_pin};
   // pin history: status bits are judged only once pins have settled
   always_ff @(posedge clk)
   begin
      h1_q <= pins;
      h2_q <= h1_q;
      h3_q <= h2_q;
      h4_q <= h3_q;
      h5_q <= h4_q;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_wait_has_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
      else $error("waitrequest dropped without request");
   a_answer_bound: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:24] !avs_waitrequest)
      else $error("request not answered in time");
   a_irq_bit: assert property (rd0 |-> avs_readdata[7] == irq)
      else $error("status A bit 7 differs from irq");
   a_bit6_mode: assert property (rd0 |-> avs_readdata[6] == (compat_alt_pin ? dma_request_out : second_drive_absent))
      else $error("status A bit 6 wrong for mode");
   a_track_layout: assert property (rd0 |-> avs_readdata[4] == (track0_n_pin ^ compat_alt_pin))
      else $error("status A bit 4 wrong for mode");
   a_index_pol: assert property (rd0 |-> avs_readdata[2] == (index_pin ^ compat_alt_pin))
      else $error("status A index polarity wrong");
   a_prot_pol: assert property (rd0 |-> avs_readdata[1] == (write_prot_pin ^ !compat_alt_pin))
      else $error("status A protect polarity wrong");
   a_dir_pol: assert property (rd0 |-> avs_readdata[0] == (step_inward ^ compat_alt_pin))
      else $error("status A direction polarity wrong");
   c_read_first: cover property (rd0 && !compat_alt_pin);
   c_read_alt: cover property (rd0 && compat_alt_pin);
   c_irq_rise: cover property ($rose(irq));
endmodule
bind fcs_top fcs_top_asserts fcs_top_asserts_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .index_pin(index_pin), .write_prot_pin(write_prot_pin), .track0_n_pin(track0_n_pin),
   .second_drive_absent(second_drive_absent), .compat_alt_pin(compat_alt_pin), .irq(irq),
   .dma_request_out(dma_request_out), .step_inward(step_inward));
`default_nettype wire

// File: testbench/test_floppy_cmd_tail_and_status_a.sv
// self-checking bench for the floppy command tail block
`default_nettype none
module test_floppy_cmd_tail_and_status_a;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, avs_read, avs_write, avs_waitrequest, irq, dma, step_inward, head_select;
   logic [2:0] avs_address;
   logic [7:0] avs_writedata, avs_readdata, rv, stat, op;
   logic [1:0] drive_select;
   logic [3:0] motor_enable;
   logic [7:0] dmp [0:9];
   fcs_pkg::fcs_pins_s ctl, drv;
   int error_cnt, n_compared;

   fcs_top fcs_top_inst (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .index_pin(drv.index), .write_prot_pin(drv.write_prot),
      .track0_n_pin(drv.track0_n), .disk_change_pin(drv.disk_change), .second_drive_absent(drv.second_drive_absent),
      .compat_alt_pin(drv.compat_alt), .irq(irq), .dma_request_out(dma), .step_inward(step_inward),
      .head_select(head_select), .drive_select(drive_select), .motor_enable(motor_enable));
   fcs_drive_model fcs_drive_model_inst (.motor_enable(motor_enable), .drive_select(drive_select),
      .ctl(ctl), .pins(drv));

   // ----------------------------------------
   // clock, watchdog
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end

   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic ack();
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      avs_write <= 1'b1;
      avs_address <= a;
      avs_writedata <= d;
      ack();
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      avs_read <= 1'b1;
      avs_address <= a;
      ack();
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask
   task automatic dump();
      wr(3'h5, 8'h0E);
      for (int i = 0; i < 10; i++) rd(3'h5, dmp[i]);
      rd(3'h4, stat);
      chk("dump_len", stat & 8'h40, 8'h00);
   endtask
   task automatic idle();
      do
         rd(3'h4, stat);
      while (stat[4] !== 1'b0);
   endtask
   task automatic settle();
      repeat (6) @(posedge clk);
   endtask
   function automatic logic [7:0] exp_sa(input logic alt, irqv, abs, tr0n, hd, idx, wp, inw);
      return alt ? {irqv, 1'b0, 1'b0, ~tr0n, ~hd, ~idx, wp, ~inw} : {irqv, abs, 1'b0, tr0n, hd, idx, ~wp, inw};
   endfunction
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 3'h0;
      avs_writedata = 8'h00;
      ctl = '0;
      error_cnt = 0;
      n_compared = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      dump();
      chk("queue_rst", dmp[8] & 8'h2F, 8'h20);
      wr(3'h2, 8'h21);
      rd(3'h1, rv);
      chk("status_b", rv, 8'hE2);
      chk("motor", {4'h0, motor_enable}, 8'h02);
      chk("drv_sel", {6'h00, drive_select}, 8'h01);
      wr(3'h1, 8'hFF);
      rd(3'h1, rv);
      chk("ro_write", rv, 8'hE2);
      rd(3'h6, rv);
      chk("unmapped", rv, 8'h00);
      rd(3'h2, rv);
      chk("wo_read", rv, 8'h00);
      wr(3'h3, 8'h02);
      rd(3'h3, rv);
      chk("tape", rv & 8'h03, 8'h02);
      rd(3'h7, rv);
      chk("din_first", rv, 8'h78);
      wr(3'h7, 8'h02);
      rd(3'h7, rv);
      chk("din_rate", rv, 8'h7D);
      wr(3'h5, 8'h13);
      wr(3'h5, 8'h00);
      wr(3'h5, 8'h45);
      wr(3'h5, 8'h2A);
      rd(3'h4, rv);
      chk("cfg_nores", rv & 8'h40, 8'h00);
      dump();
      chk("cfg_bits", dmp[8], 8'h45);
      chk("precomp_start_track", dmp[9], 8'h2A);
      for (int i = 0; i < 2; i++)
      begin
         op = (i == 0) ? 8'h94 : 8'h14;
         wr(3'h5, op);
         rd(3'h5, rv);
         chk("lock_res", rv, {3'h0, op[7], 4'h0});
         dump();
         chk("lock_dump", dmp[7] & 8'h80, {op[7], 7'h00});
      end
      wr(3'h5, 8'h12);
      wr(3'h5, 8'h96);
      wr(3'h5, 8'h03);
      wr(3'h5, 8'hAB);
      wr(3'h5, 8'h35);
      dump();
      chk("perp", dmp[7], 8'h16);
      chk("spec_a", dmp[4], 8'hAB);
      chk("spec_b", dmp[5], 8'h35);
      chk("eot", dmp[6], 8'h00);
      wr(3'h5, 8'hCF);
      wr(3'h5, 8'h05);
      wr(3'h5, 8'h03);
      idle();
      chk("dir_in", {6'h00, head_select, step_inward}, 8'h03);
      chk("irq_set", {7'h00, irq}, 8'h01);
      for (int m = 0; m < 2; m++)
         for (int p = 0; p < 2; p++)
         begin
            ctl.compat_alt <= m[0];
            ctl.write_prot <= ~p[0];
            ctl.track0_n <= p[0];
            ctl.index <= ~p[0];
            ctl.second_drive_absent <= ~p[0];
            settle();
            rd(3'h0, rv);
            chk("status_a", rv, exp_sa(m[0], 1'b1, ~p[0], p[0], 1'b1, ~p[0], ~p[0], 1'b1));
         end
      wr(3'h5, 8'h8F);
      wr(3'h5, 8'h05);
      wr(3'h5, 8'h01);
      idle();
      rd(3'h0, rv);
      chk("status_a_out", rv, exp_sa(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
      dump();
      chk("pcn_drive1", dmp[1], 8'h02);
      ctl.write_prot <= 1'b1;
      ctl.track0_n <= 1'b0;
      settle();
      wr(3'h5, 8'h04);
      wr(3'h5, 8'h05);
      rd(3'h5, rv);
      chk("sense", rv, 8'h7D);
      wr(3'h5, 8'h00);
      rd(3'h5, rv);
      chk("invalid", rv, 8'h80);
      rd(3'h4, rv);
      chk("invalid_one", rv & 8'h40, 8'h00);
      wr(3'h4, 8'h80);
      dump();
      chk("sreset_cfg", dmp[8], 8'h20);
      print_verdict();
   end
endmodule
`default_nettype wire
